// ===== logic/dac_ctrl_pkg.sv
package dac_ctrl_pkg;
  localparam int SAMPLE_W   = 14;
  localparam int FIFO_DEPTH = 8;
  localparam int APB_AW     = 12;

  // apb register map
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] SERCFG_OFS = 12'h008;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int CTRL_RUN_BIT        = 0;
  localparam int STAT_SPI_BIT        = 0;
  localparam int STAT_TWOS_BIT       = 1;
  localparam int STAT_DIFF_BIT       = 2;
  localparam int STAT_PDOWN_BIT      = 3;
  localparam int STAT_BUSY_BIT       = 4;
  localparam int STAT_LEVEL_LSB      = 8;

  // serial frame: r/w bit, 7-bit address, 8 data bits, msb first
  localparam logic [2:0] SPI_PHASE_LAST = 3'h7;
  localparam logic [6:0] SPI_CFG_ADDR   = 7'h00;
  localparam logic [7:0] SPI_CFG_RESET  = 8'h00;
  localparam int CFG_TWOS_BIT           = 0;
  localparam int CFG_DIFF_BIT           = 1;
  localparam int CFG_PDOWN_BIT          = 2;

  typedef enum logic [2:0] {
    SPI_IDLE  = 3'b000,
    SPI_CMD   = 3'b001,
    SPI_WDATA = 3'b010,
    SPI_RDATA = 3'b011,
    SPI_DONE  = 3'b100
  } spi_state_t;
endpackage

// ===== logic/sample_fifo.sv
`timescale 1ns/10ps
module sample_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign in_ready  = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_reg];
  assign level     = cnt_reg;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// ===== logic/dac_pin_spi_ctrl.sv
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module dac_pin_spi_ctrl #(
  parameter int SAMPLE_W   = dac_ctrl_pkg::SAMPLE_W,
  parameter int FIFO_DEPTH = dac_ctrl_pkg::FIFO_DEPTH
) (
  input  wire logic                          CORE_CLK,
  input  wire logic                          RST_N,
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [dac_ctrl_pkg::APB_AW-1:0] PADDR,
  input  wire logic [31:0]                   PWDATA,
  output logic [31:0]                        PRDATA,
  output logic                               PREADY,
  output logic                               PSLVERR,
  input  wire logic                          INTERFACE_SELECT,
  input  wire logic                          FORMAT_STRAP_OR_SDIO_I,
  output logic                               SDIO_O,
  output logic                               SDIO_OE,
  input  wire logic                          CLOCK_TYPE_STRAP_OR_SERIAL_CLOCK,
  input  wire logic                          POWERDOWN_OR_CHIP_SELECT_N,
  input  wire logic                          SAMPLE_VALID,
  output logic                               SAMPLE_READY,
  input  wire logic [SAMPLE_W-1:0]           SAMPLE_WORD,
  output logic [SAMPLE_W-1:0]                PRIMARY_CURRENT_OUT,
  output logic [SAMPLE_W-1:0]                COMPLEMENTARY_CURRENT_OUT,
  output logic                               SPI_MODE,
  output logic                               TWOS_COMPLEMENT,
  output logic                               DIFF_CLOCK_SEL,
  output logic                               POWER_DOWN
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  dac_ctrl_pkg::spi_state_t state_reg;
  logic                spi_mode;
  logic                cs_active;
  logic                sclk_q_reg;
  logic                sclk_rise;
  logic                sclk_fall;
  logic [2:0]          bit_cnt_reg;
  logic [6:0]          shift_reg;
  logic [7:0]          cmd_byte;
  logic [7:0]          data_byte;
  logic [6:0]          addr_reg;
  logic [7:0]          rd_shift_reg;
  logic [7:0]          spi_rdata;
  logic                sdo_reg;
  logic [7:0]          cfg_reg;
  logic                twos_next;
  logic                diff_next;
  logic                pdown_next;
  logic                spi_mode_reg;
  logic                twos_reg;
  logic                diff_reg;
  logic                pdown_reg;
  logic [31:0]         ctrl_reg;
  logic [31:0]         prdata_reg;
  logic [31:0]         rd_mux;
  logic                apb_setup;
  logic                apb_write;
  logic                addr_ok;
  logic                fifo_valid;
  logic                fifo_pop_ready;
  logic                fifo_pop;
  logic [SAMPLE_W-1:0] fifo_data;
  logic [LW-1:0]       fifo_level;
  logic [SAMPLE_W-1:0] prim_reg;
  logic [SAMPLE_W-1:0] msb_flip;

  ////////////////////////////////////////////////////////////////////////////
  // mode and effective settings

  assign spi_mode = !INTERFACE_SELECT;

  // strap meanings ignored while serial mode is selected
  always_comb begin
    if (spi_mode) begin
      twos_next  = cfg_reg[dac_ctrl_pkg::CFG_TWOS_BIT];
      diff_next  = cfg_reg[dac_ctrl_pkg::CFG_DIFF_BIT];
      pdown_next = cfg_reg[dac_ctrl_pkg::CFG_PDOWN_BIT];
    end else begin
      twos_next  = FORMAT_STRAP_OR_SDIO_I;
      diff_next  = CLOCK_TYPE_STRAP_OR_SERIAL_CLOCK;
      pdown_next = POWERDOWN_OR_CHIP_SELECT_N;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      spi_mode_reg <= 1'b0;
      twos_reg     <= 1'b0;
      diff_reg     <= 1'b0;
      pdown_reg    <= 1'b0;
    end else begin
      spi_mode_reg <= spi_mode;
      twos_reg     <= twos_next;
      diff_reg     <= diff_next;
      pdown_reg    <= pdown_next;
    end
  end

  assign SPI_MODE        = spi_mode_reg;
  assign TWOS_COMPLEMENT = twos_reg;
  assign DIFF_CLOCK_SEL  = diff_reg;
  assign POWER_DOWN      = pdown_reg;

  ////////////////////////////////////////////////////////////////////////////
  // serial port: sample on serial clock rise, drive on fall

  assign cs_active = spi_mode && !POWERDOWN_OR_CHIP_SELECT_N;
  assign sclk_rise = cs_active && CLOCK_TYPE_STRAP_OR_SERIAL_CLOCK && !sclk_q_reg;
  assign sclk_fall = cs_active && !CLOCK_TYPE_STRAP_OR_SERIAL_CLOCK && sclk_q_reg;
  assign cmd_byte  = {shift_reg, FORMAT_STRAP_OR_SDIO_I};
  assign data_byte = cmd_byte;
  assign spi_rdata = (cmd_byte[6:0] == dac_ctrl_pkg::SPI_CFG_ADDR) ? cfg_reg : 8'h00;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sclk_q_reg <= 1'b0;
    end else begin
      sclk_q_reg <= CLOCK_TYPE_STRAP_OR_SERIAL_CLOCK;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg    <= dac_ctrl_pkg::SPI_IDLE;
      bit_cnt_reg  <= 3'h0;
      shift_reg    <= 7'h00;
      addr_reg     <= 7'h00;
      rd_shift_reg <= 8'h00;
    end else if (!cs_active) begin
      // chip select high aborts any partial frame
      state_reg   <= dac_ctrl_pkg::SPI_IDLE;
      bit_cnt_reg <= 3'h0;
    end else begin
      case (state_reg)
        dac_ctrl_pkg::SPI_IDLE: begin
          state_reg   <= dac_ctrl_pkg::SPI_CMD;
          bit_cnt_reg <= 3'h0;
        end
        dac_ctrl_pkg::SPI_CMD: begin
          if (sclk_rise) begin
            shift_reg   <= cmd_byte[6:0];
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == dac_ctrl_pkg::SPI_PHASE_LAST) begin
              addr_reg     <= cmd_byte[6:0];
              rd_shift_reg <= spi_rdata;
              state_reg    <= cmd_byte[7] ? dac_ctrl_pkg::SPI_RDATA
                                          : dac_ctrl_pkg::SPI_WDATA;
            end
          end
        end
        dac_ctrl_pkg::SPI_WDATA: begin
          if (sclk_rise) begin
            shift_reg   <= cmd_byte[6:0];
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == dac_ctrl_pkg::SPI_PHASE_LAST) begin
              state_reg <= dac_ctrl_pkg::SPI_DONE;
            end
          end
        end
        dac_ctrl_pkg::SPI_RDATA: begin
          if (sclk_fall) begin
            rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
          end
          if (sclk_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == dac_ctrl_pkg::SPI_PHASE_LAST) begin
              state_reg <= dac_ctrl_pkg::SPI_DONE;
            end
          end
        end
        default: begin
          // extra clocks after a frame are ignored until deselect
          state_reg <= dac_ctrl_pkg::SPI_DONE;
        end
      endcase
    end
  end

  // read data leaves msb first, one bit per falling serial clock
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sdo_reg <= 1'b0;
    end else if (state_reg == dac_ctrl_pkg::SPI_RDATA && sclk_fall) begin
      sdo_reg <= rd_shift_reg[7];
    end
  end

  assign SDIO_O  = sdo_reg;
  assign SDIO_OE = cs_active && state_reg == dac_ctrl_pkg::SPI_RDATA;

  // select held high keeps the serial register at its default
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_reg <= dac_ctrl_pkg::SPI_CFG_RESET;
    end else if (INTERFACE_SELECT) begin
      cfg_reg <= dac_ctrl_pkg::SPI_CFG_RESET;
    end else if (cs_active && state_reg == dac_ctrl_pkg::SPI_WDATA && sclk_rise
                 && bit_cnt_reg == dac_ctrl_pkg::SPI_PHASE_LAST
                 && addr_reg == dac_ctrl_pkg::SPI_CFG_ADDR) begin
      cfg_reg <= data_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample path

  // host keeps msb at the top bit; a full fifo stalls it
  sample_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CORE_CLK),
    .rst_n     (RST_N),
    .in_valid  (SAMPLE_VALID),
    .in_ready  (SAMPLE_READY),
    .in_data   (SAMPLE_WORD),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop_ready),
    .out_data  (fifo_data),
    .level     (fifo_level)
  );

  // powered down or stopped: fifo backs up rather than dropping words
  assign fifo_pop_ready = ctrl_reg[dac_ctrl_pkg::CTRL_RUN_BIT] && !pdown_reg;
  assign fifo_pop       = fifo_valid && fifo_pop_ready;
  assign msb_flip       = {twos_reg, {(SAMPLE_W-1){1'b0}}};

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      prim_reg <= '0;
    end else if (fifo_pop) begin
      prim_reg <= fifo_data ^ msb_flip;
    end
  end

  assign PRIMARY_CURRENT_OUT       = prim_reg;
  assign COMPLEMENTARY_CURRENT_OUT = ~prim_reg;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states

  assign apb_setup = PSEL && !PENABLE;
  assign apb_write = PSEL && PENABLE && PWRITE;
  assign addr_ok   = PADDR == dac_ctrl_pkg::CTRL_OFS || PADDR == dac_ctrl_pkg::STATUS_OFS
                     || PADDR == dac_ctrl_pkg::SERCFG_OFS;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (PADDR == dac_ctrl_pkg::CTRL_OFS) begin
      rd_mux = ctrl_reg;
    end else if (PADDR == dac_ctrl_pkg::STATUS_OFS) begin
      rd_mux[dac_ctrl_pkg::STAT_SPI_BIT]   = spi_mode_reg;
      rd_mux[dac_ctrl_pkg::STAT_TWOS_BIT]  = twos_reg;
      rd_mux[dac_ctrl_pkg::STAT_DIFF_BIT]  = diff_reg;
      rd_mux[dac_ctrl_pkg::STAT_PDOWN_BIT] = pdown_reg;
      rd_mux[dac_ctrl_pkg::STAT_BUSY_BIT]  = state_reg != dac_ctrl_pkg::SPI_IDLE;
      rd_mux[dac_ctrl_pkg::STAT_LEVEL_LSB +: LW] = fifo_level;
    end else if (PADDR == dac_ctrl_pkg::SERCFG_OFS) begin
      rd_mux[7:0] = cfg_reg;
    end
  end

  // read data captured in the setup cycle so it leaves a flip-flop
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_reg <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg <= dac_ctrl_pkg::CTRL_RESET;
    end else if (apb_write && PADDR == dac_ctrl_pkg::CTRL_OFS) begin
      ctrl_reg <= {31'h0000_0000, PWDATA[dac_ctrl_pkg::CTRL_RUN_BIT]};
    end
  end

  assign PRDATA  = prdata_reg;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  mode_follows_select_a: assert property ($past(RST_N) |-> SPI_MODE == !$past(INTERFACE_SELECT))
    else $error("mode does not follow select");
  select_resets_cfg_a: assert property (INTERFACE_SELECT |=> cfg_reg == dac_ctrl_pkg::SPI_CFG_RESET)
    else $error("serial register not at default");
  strap_format_a: assert property (INTERFACE_SELECT |=> TWOS_COMPLEMENT == $past(FORMAT_STRAP_OR_SDIO_I))
    else $error("format strap not honoured");
  sdio_drive_gate_a: assert property (SDIO_OE |-> !POWERDOWN_OR_CHIP_SELECT_N
    && ($past(SDIO_OE) || $past(sclk_rise) && $past(state_reg) == dac_ctrl_pkg::SPI_CMD))
    else $error("data line driven outside a frame");
  strap_clock_a: assert property (INTERFACE_SELECT |=> DIFF_CLOCK_SEL == $past(CLOCK_TYPE_STRAP_OR_SERIAL_CLOCK))
    else $error("clock strap not honoured");
  serial_clock_count_a: assert property (sclk_rise && state_reg == dac_ctrl_pkg::SPI_CMD
    |=> bit_cnt_reg == $past(bit_cnt_reg) + 3'h1)
    else $error("serial clock edge not counted");
  strap_sleep_a: assert property (INTERFACE_SELECT && POWERDOWN_OR_CHIP_SELECT_N
    |=> POWER_DOWN && !fifo_pop)
    else $error("sleep strap not honoured");
  deselect_idle_a: assert property (!INTERFACE_SELECT && POWERDOWN_OR_CHIP_SELECT_N
    |=> state_reg == dac_ctrl_pkg::SPI_IDLE && !SDIO_OE)
    else $error("frame continues without chip select");
  outputs_mirror_a: assert property (COMPLEMENTARY_CURRENT_OUT == ~PRIMARY_CURRENT_OUT)
    else $error("outputs are not complementary");
  msb_inverted_a: assert property (fifo_pop
    |=> PRIMARY_CURRENT_OUT == ($past(fifo_data) ^ $past(msb_flip)))
    else $error("sample capture wrong");
  serial_settings_a: assert property (!INTERFACE_SELECT |=> POWER_DOWN == $past(cfg_reg[dac_ctrl_pkg::CFG_PDOWN_BIT]))
    else $error("serial setting not applied");

  read_frame_c: cover property (state_reg == dac_ctrl_pkg::SPI_RDATA ##[1:400] state_reg == dac_ctrl_pkg::SPI_DONE);
  cfg_write_c: cover property (!INTERFACE_SELECT && $changed(cfg_reg));
  fifo_full_c: cover property (SAMPLE_VALID && !SAMPLE_READY);
  twos_sample_c: cover property (fifo_pop && twos_reg);
endmodule

// ===== verification/host_model.sv
`timescale 1ns/10ps
module host_model (
  input  wire logic                              clk,
  input  wire logic                              sdio_o,
  input  wire logic                              sdio_oe,
  input  wire logic                              sample_ready,
  output logic                                   sdio_line,
  output logic                                   clk_pin,
  output logic                                   cs_pin,
  output logic                                   sample_valid,
  output logic [dac_ctrl_pkg::SAMPLE_W-1:0]      sample_word
);
  logic host_oe;
  logic host_d;
  logic last_bit;

  initial begin
    host_oe = 1'b1;
    host_d = 1'b0;
    last_bit = 1'b0;
    clk_pin = 1'b0;
    cs_pin = 1'b0;
    sample_valid = 1'b0;
    sample_word = '0;
  end

  // a released line toggles so a settled 0 or 1 never looks like data
  always_comb begin
    if (sdio_oe)
      sdio_line = sdio_o;
    else if (host_oe)
      sdio_line = host_d;
    else
      sdio_line = ~last_bit;
  end

  always @(posedge clk) last_bit <= sdio_line;

  task automatic straps(input logic fmt, input logic ck, input logic pd);
    @(posedge clk);
    host_oe <= 1'b1;
    host_d <= fmt;
    clk_pin <= ck;
    cs_pin <= pd;
  endtask

  task automatic push(input logic [dac_ctrl_pkg::SAMPLE_W-1:0] w);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample_word <= w;
    do begin
      @(posedge clk);
    end while (sample_ready !== 1'b1);
    sample_valid <= 1'b0;
    sample_word <= ~w;
  endtask

  // serial clock high lasts 3 core cycles and low lasts 4, above the 2-cycle minimum
  task automatic frame(input logic [15:0] b, input int nb, output logic [7:0] rd);
    @(posedge clk);
    cs_pin <= 1'b0;
    clk_pin <= 1'b0;
    repeat (3) @(posedge clk);
    for (int i = 15; i >= 16 - nb; i--) begin
      host_d <= b[i];
      repeat (3) @(posedge clk);
      @(negedge clk);
      rd = {rd[6:0], sdio_line};
      @(posedge clk);
      clk_pin <= 1'b1;
      repeat (3) @(posedge clk);
      clk_pin <= 1'b0;
      // let go only after the last command bit has been sampled
      host_oe <= !(b[15] && i <= 8);
    end
    repeat (3) @(posedge clk);
    cs_pin <= 1'b1;
    host_oe <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
endmodule

// ===== verification/tb.sv
`timescale 1ns/10ps
`define CHK(nm, ex, g) begin samples_checked++; if ((g) !== (ex)) begin \
  $display("mismatch %s expected %h seen %h", nm, ex, g); n_fail++; end end
module tb;
  logic        CORE_CLK;
  logic        RST_N;
  logic        PSEL;
  logic        PENABLE;
  logic        PWRITE;
  logic [11:0] PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        INTERFACE_SELECT;
  logic        sdio_line;
  logic        SDIO_O;
  logic        SDIO_OE;
  logic        clk_pin;
  logic        cs_pin;
  logic        SAMPLE_VALID;
  logic        SAMPLE_READY;
  logic [13:0] SAMPLE_WORD;
  logic [13:0] PRIMARY_CURRENT_OUT;
  logic [13:0] COMPLEMENTARY_CURRENT_OUT;
  logic        SPI_MODE;
  logic        TWOS_COMPLEMENT;
  logic        DIFF_CLOCK_SEL;
  logic        POWER_DOWN;
  logic [31:0] d;
  logic        e;
  logic [7:0]  r;
  logic [13:0] words [4] = '{14'h0000, 14'h3FFF, 14'h2000, 14'h1555};
  int          n_fail = 0;
  int          samples_checked = 0;

  dac_pin_spi_ctrl i_dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .INTERFACE_SELECT(INTERFACE_SELECT), .FORMAT_STRAP_OR_SDIO_I(sdio_line),
    .SDIO_O(SDIO_O), .SDIO_OE(SDIO_OE), .CLOCK_TYPE_STRAP_OR_SERIAL_CLOCK(clk_pin),
    .POWERDOWN_OR_CHIP_SELECT_N(cs_pin), .SAMPLE_VALID(SAMPLE_VALID),
    .SAMPLE_READY(SAMPLE_READY), .SAMPLE_WORD(SAMPLE_WORD),
    .PRIMARY_CURRENT_OUT(PRIMARY_CURRENT_OUT),
    .COMPLEMENTARY_CURRENT_OUT(COMPLEMENTARY_CURRENT_OUT), .SPI_MODE(SPI_MODE),
    .TWOS_COMPLEMENT(TWOS_COMPLEMENT), .DIFF_CLOCK_SEL(DIFF_CLOCK_SEL),
    .POWER_DOWN(POWER_DOWN));

  host_model m (.clk(CORE_CLK), .sdio_o(SDIO_O), .sdio_oe(SDIO_OE),
    .sample_ready(SAMPLE_READY), .sdio_line(sdio_line), .clk_pin(clk_pin),
    .cs_pin(cs_pin), .sample_valid(SAMPLE_VALID), .sample_word(SAMPLE_WORD));

  always #20 CORE_CLK = ~CORE_CLK;

  ////////////////////////////////////////
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CORE_CLK);
    end while (PREADY !== 1'b1);
    d = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic chk_out(input logic [13:0] x);
    `CHK("primary", x, PRIMARY_CURRENT_OUT)
    `CHK("complementary", ~x, COMPLEMENTARY_CURRENT_OUT)
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // a full run is about a thousand cycles
  initial begin
    repeat (30000) @(posedge CORE_CLK);
    n_fail++;
    summarize();
  end

  initial begin
    CORE_CLK = 1'b0;
    RST_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = '0;
    PWDATA = '0;
    INTERFACE_SELECT = 1'b1;
    repeat (3) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    chk_out(14'h0000);
    apb(1'b0, dac_ctrl_pkg::CTRL_OFS, '0);
    `CHK("ctrl", dac_ctrl_pkg::CTRL_RESET, d)
    apb(1'b0, 12'h00C, '0);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0000_0000, d)
    for (int i = 0; i < 8; i++) begin
      m.straps(i[0], i[1], i[2]);
      repeat (3) @(posedge CORE_CLK);
      `CHK("spi mode", 1'b0, SPI_MODE)
      `CHK("twos", i[0], TWOS_COMPLEMENT)
      `CHK("diff", i[1], DIFF_CLOCK_SEL)
      `CHK("pdown", i[2], POWER_DOWN)
      apb(1'b0, dac_ctrl_pkg::STATUS_OFS, '0);
      `CHK("status", {28'h000_0000, i[2:0], 1'b0}, d & 32'h0000_0F1F)
    end
    for (int f = 0; f < 2; f++) begin
      m.straps(f[0], 1'b0, 1'b0);
      for (int k = 0; k < 4; k++) begin
        m.push(words[k]);
        repeat (3) @(posedge CORE_CLK);
        chk_out(words[k] ^ {f[0], 13'h0000});
      end
    end
    m.straps(1'b0, 1'b0, 1'b1);
    m.push(14'h0ABC);
    repeat (5) @(posedge CORE_CLK);
    chk_out(14'h3555);
    m.straps(1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge CORE_CLK);
    chk_out(14'h0ABC);
    // drain stopped so the fifo fills and refuses
    apb(1'b1, dac_ctrl_pkg::CTRL_OFS, 32'h0000_0000);
    for (int k = 0; k < 8; k++) m.push(14'h0100 | 14'(k));
    repeat (2) @(posedge CORE_CLK);
    `CHK("ready full", 1'b0, SAMPLE_READY)
    apb(1'b0, dac_ctrl_pkg::STATUS_OFS, '0);
    `CHK("level", 4'h8, d[11:8])
    apb(1'b1, dac_ctrl_pkg::CTRL_OFS, 32'h0000_0001);
    repeat (20) @(posedge CORE_CLK);
    chk_out(14'h0107);
    m.straps(1'b1, 1'b0, 1'b1);
    @(posedge CORE_CLK);
    INTERFACE_SELECT <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
    `CHK("spi mode", 1'b1, SPI_MODE)
    `CHK("twos ign", 1'b0, TWOS_COMPLEMENT)
    `CHK("pdown ign", 1'b0, POWER_DOWN)
    m.frame(16'h0003, 16, r);
    `CHK("twos cfg", 1'b1, TWOS_COMPLEMENT)
    `CHK("diff cfg", 1'b1, DIFF_CLOCK_SEL)
    m.frame(16'h8000, 16, r);
    `CHK("serial read", 8'h03, r)
    `CHK("oe idle", 1'b0, SDIO_OE)
    m.frame(16'h0504, 16, r);
    m.frame(16'h8500, 16, r);
    `CHK("other addr", 8'h00, r)
    m.frame(16'h0004, 12, r);
    apb(1'b0, dac_ctrl_pkg::SERCFG_OFS, '0);
    `CHK("abort", 32'h0000_0003, d)
    m.frame(16'h0005, 16, r);
    `CHK("pdown cfg", 1'b1, POWER_DOWN)
    m.frame(16'h0001, 16, r);
    m.push(14'h0000);
    repeat (3) @(posedge CORE_CLK);
    chk_out(14'h2000);
    INTERFACE_SELECT <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    INTERFACE_SELECT <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
    apb(1'b0, dac_ctrl_pkg::SERCFG_OFS, '0);
    `CHK("cfg pulse", 32'h0000_0000, d)
    `CHK("twos pulse", 1'b0, TWOS_COMPLEMENT)
    summarize();
  end
endmodule
